// >>> sbs_burst_cnt.sv
// Two-bit burst address counter with linear and interleaved order
`timescale 1ns/100ps
module sbs_burst_cnt import sbs_pkg::*; (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic srst_in,
    // Control from the port logic
    sbs_burst_if.cnt_side bus
);
    typedef struct packed {
        logic [SBS_BURST_W-1:0] start;
        logic [SBS_BURST_W-1:0] cnt;
    } sbs_cnt_s;

    sbs_cnt_s st_r;
    sbs_cnt_s st_nxt;

    // Low address bits of the current beat
    function automatic logic [SBS_BURST_W-1:0] sbs_beat_low(input logic mode, input logic [SBS_BURST_W-1:0] s,
                                                            input logic [SBS_BURST_W-1:0] c);
        sbs_beat_low = mode ? (s ^ c) : SBS_BURST_W'(s + c);
    endfunction : sbs_beat_low

    // Load on a new burst, step on advance, hold otherwise
    always_comb begin
        st_nxt = st_r;
        if (bus.load) begin
            st_nxt.start = bus.start;
            st_nxt.cnt = SBS_BURST_ZERO;
        end else if (bus.step) begin
            st_nxt.cnt = SBS_BURST_W'(st_r.cnt + SBS_BURST_ONE); // Wraps after four beats
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign bus.cnt = st_r.cnt;
    assign bus.low = sbs_beat_low(bus.mode, st_r.start, st_r.cnt);

    // Interleaved step flips exactly the bits that change in the beat count
    property p_interleave_step;
        @(posedge core_clk_in) disable iff (srst_in)
        (bus.step && !bus.load && bus.mode) ##1 bus.mode |->
            (bus.low ^ $past(bus.low)) == ($past(bus.cnt) ^ SBS_BURST_W'($past(bus.cnt) + SBS_BURST_ONE));
    endproperty
    a_interleave_step: assert property (p_interleave_step) else $error("interleaved step wrong");

    // Four linear steps come back to the start value
    property p_linear_wrap;
        @(posedge core_clk_in) disable iff (srst_in)
        (bus.step && !bus.load && !bus.mode) [*4] ##1 !bus.mode |-> bus.low == $past(bus.low, 4);
    endproperty
    a_linear_wrap: assert property (p_linear_wrap) else $error("linear burst does not wrap at four");
endmodule : sbs_burst_cnt

// >>> sbs_burst_if.sv
// Link between the port logic and its burst address counter
`timescale 1ns/100ps
interface sbs_burst_if import sbs_pkg::*; ();
    logic load;
    logic step;
    logic mode;
    logic [SBS_BURST_W-1:0] start;
    logic [SBS_BURST_W-1:0] low;
    logic [SBS_BURST_W-1:0] cnt;

    modport ctl (output load, output step, output mode, output start, input low, input cnt);
    modport cnt_side (input load, input step, input mode, input start, output low, output cnt);
endinterface : sbs_burst_if

// >>> sbs_bus_model.sv
// Far-side bus model: resolves the shared data wires between the master and the device
`timescale 1ns/100ps
module sbs_bus_model import sbs_pkg::*; #(
    parameter int DATA_W = SBS_DATA_W_WIDE
) (
    // Clock
    input wire logic core_clk_in,
    // Master side
    input wire logic drive_in,
    input wire logic [DATA_W-1:0] wdata_in,
    // Device side
    input wire logic [DATA_W-1:0] dq_out_in,
    input wire logic dq_oe_in,
    // Resolved wire level
    output logic [DATA_W-1:0] bus_out
);
    logic [DATA_W-1:0] last_r;

    // Released wires flip every cycle, so a stale level never passes for a read
    always_comb begin
        if (drive_in) begin
            bus_out = wdata_in;
        end else if (dq_oe_in) begin
            bus_out = dq_out_in;
        end else begin
            bus_out = ~last_r;
        end
    end

    // Last level seen on the wires
    always_ff @(posedge core_clk_in) begin
        last_r <= bus_out;
    end
endmodule : sbs_bus_model

// >>> sbs_pkg.sv
// Shared constants for the synchronous burst memory port
//------------------------------------------------------------------------------
// What this block does
// - A two-bit burst counter loads the low address bits when a burst starts and then steps to make the rest.
// - Address, write data, all chip selects, both strobes, advance and all write enables are sampled on the rising edge.
// - Output enable and sleep request are asynchronous inputs with no tie to any clock edge.
// - The burst order select input high gives interleaved order and low gives linear order.
// - Either the processor strobe or the controller strobe starts a burst access.
// - The burst address advances only when burst advance is asserted at a clock edge.
// - Address and chip select state are loaded only at an edge where one of the two strobes is active.
// - A four-beat burst gives its first beat two cycles after the access starts and each later beat one cycle apart.
// - Storage is 512K words of 36 bits or 1M words of 18 bits on one shared two-way data bus.
// - A primary chip select is registered with the address, plus one high and one low depth expansion select.
// - A reduced variant keeps only the primary chip select and ignores the depth expansion selects.
// - A low-power sleep state is entered through the asynchronous sleep request input.
//------------------------------------------------------------------------------
package sbs_pkg;
    // Array shape, wide organisation by default
    localparam int SBS_ADDR_W_WIDE = 19;
    localparam int SBS_DATA_W_WIDE = 36;
    localparam int SBS_ADDR_W_NARROW = 20;
    localparam int SBS_DATA_W_NARROW = 18;
    localparam int SBS_LANE_W = 9;
    // Burst counter
    localparam int SBS_BURST_W = 2;
    localparam logic [SBS_BURST_W-1:0] SBS_BURST_ZERO = 2'h0;
    localparam logic [SBS_BURST_W-1:0] SBS_BURST_ONE = 2'h1;
    // Timing figures in clock cycles
    localparam int SBS_FIRST_BEAT_CYC = 2;
    localparam int SBS_NEXT_BEAT_CYC = 1;
endpackage : sbs_pkg

// >>> sbs_port.sv
// Synchronous burst memory port: strobes, burst control, byte writes and storage
`timescale 1ns/100ps
module sbs_port import sbs_pkg::*; #(
    parameter int ADDR_W = SBS_ADDR_W_WIDE,
    parameter int DATA_W = SBS_DATA_W_WIDE,
    parameter bit DEPTH_SEL_EN = 1'b1
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic srst_in,
    // Address and burst control, sampled on the rising edge
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic processor_addr_strobe_n_in,
    input wire logic controller_addr_strobe_n_in,
    input wire logic burst_advance_n_in,
    input wire logic burst_mode_in,
    // Chip selects
    input wire logic primary_chip_select_n_in,
    input wire logic depth_select_high_in,
    input wire logic depth_select_low_n_in,
    // Write enables
    input wire logic [DATA_W/SBS_LANE_W-1:0] byte_write_lane_n_in,
    input wire logic byte_write_qualifier_n_in,
    input wire logic global_write_n_in,
    // Asynchronous controls
    input wire logic out_enable_n_in,
    input wire logic sleep_request_in,
    // Shared data bus, split into its three signals
    input wire logic [DATA_W-1:0] dq_in,
    output logic [DATA_W-1:0] dq_out,
    output logic dq_oe_out,
    output logic sleep_active_out
);
    localparam int LANES = DATA_W / SBS_LANE_W;
    localparam int DEPTH = 2 ** ADDR_W;

    // Only the two documented organisations fit the lane and counter logic
    if (!((ADDR_W == SBS_ADDR_W_WIDE && DATA_W == SBS_DATA_W_WIDE) ||
          (ADDR_W == SBS_ADDR_W_NARROW && DATA_W == SBS_DATA_W_NARROW))) begin : g_bad_shape
        $error("sbs_port: unsupported array organisation");
    end

    typedef struct packed {
        logic oe_meta;
        logic oe_n_sync;
        logic sleep_meta;
        logic sleep_sync;
        logic active;
        logic [ADDR_W-1:SBS_BURST_W] base;
        logic [DATA_W-1:0] dout;
        logic dq_oe;
    } sbs_port_s;

    sbs_port_s st_r;
    sbs_port_s st_nxt;
    logic [DATA_W-1:0] mem_r [DEPTH];

    sbs_burst_if burst ();

    //--------------------------------------------------------------------------
    // Input decode
    //--------------------------------------------------------------------------

    // Chip is selected when all enabled selects agree
    function automatic logic sbs_selected(input logic prim_n, input logic dhigh, input logic dlow_n);
        sbs_selected = !prim_n && (!DEPTH_SEL_EN || (dhigh && !dlow_n));
    endfunction : sbs_selected

    logic p_strobe;
    logic c_strobe;
    logic strobe;
    logic selected;
    logic wr_any;
    logic [LANES-1:0] wr_lanes;
    logic [ADDR_W-1:0] cur_addr;

    // The processor strobe is ignored while the primary select is off, so
    // another part on the bus can own the cycle. Sleep blocks new accesses.
    always_comb begin
        p_strobe = !processor_addr_strobe_n_in && !primary_chip_select_n_in;
        c_strobe = !controller_addr_strobe_n_in;
        strobe = (p_strobe || c_strobe) && !st_r.sleep_sync;
        selected = sbs_selected(primary_chip_select_n_in, depth_select_high_in, depth_select_low_n_in);
    end

    // Lane enables: global write takes all lanes, the qualifier takes the chosen ones
    always_comb begin
        if (!global_write_n_in) begin
            wr_lanes = '1;
        end else if (!byte_write_qualifier_n_in) begin
            wr_lanes = ~byte_write_lane_n_in;
        end else begin
            wr_lanes = '0;
        end
        // Writes belong to a running burst; a fresh strobe edge only addresses
        wr_any = st_r.active && !strobe && !st_r.sleep_sync && (wr_lanes != '0);
    end

    assign cur_addr = {st_r.base, burst.low};

    //--------------------------------------------------------------------------
    // Burst counter
    //--------------------------------------------------------------------------

    // Counter loads at a strobe and steps on advance within a burst
    always_comb begin
        burst.load = strobe;
        burst.start = addr_in[SBS_BURST_W-1:0];
        burst.step = st_r.active && !strobe && !burst_advance_n_in;
        burst.mode = burst_mode_in;
    end

    sbs_burst_cnt u_cnt (
        .core_clk_in(core_clk_in),
        .srst_in(srst_in),
        .bus(burst.cnt_side)
    );

    //--------------------------------------------------------------------------
    // Port state
    //--------------------------------------------------------------------------

    // Next state. Output enable and sleep may change at any moment, so each
    // passes two flops; that costs two cycles of reaction on those pins.
    always_comb begin
        st_nxt = st_r;
        st_nxt.oe_meta = out_enable_n_in;
        st_nxt.oe_n_sync = st_r.oe_meta;
        st_nxt.sleep_meta = sleep_request_in;
        st_nxt.sleep_sync = st_r.sleep_meta;
        if (strobe) begin
            st_nxt.base = addr_in[ADDR_W-1:SBS_BURST_W];
            st_nxt.active = selected;
        end else if (st_r.sleep_sync) begin
            st_nxt.active = 1'b0;
        end
        // Pipelined read: the word at the burst address is registered one
        // edge after it is addressed, so the first beat is seen two edges on
        st_nxt.dout = mem_r[cur_addr];
        st_nxt.dq_oe = st_r.active && !wr_any && !st_r.oe_n_sync && !st_r.sleep_sync;
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            st_r <= '0;
            st_r.oe_meta <= 1'b1;
            st_r.oe_n_sync <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Storage with byte lanes; parity bits ride in each lane's top bit
    always_ff @(posedge core_clk_in) begin
        for (int i = 0; i < LANES; i++) begin
            if (wr_any && wr_lanes[i]) begin
                mem_r[cur_addr][i*SBS_LANE_W +: SBS_LANE_W] <= dq_in[i*SBS_LANE_W +: SBS_LANE_W];
            end
        end
    end

    assign dq_out = st_r.dout;
    assign dq_oe_out = st_r.dq_oe;
    assign sleep_active_out = st_r.sleep_sync;

    //--------------------------------------------------------------------------
    // Checks
    //--------------------------------------------------------------------------

    property p_addr_load;
        @(posedge core_clk_in) disable iff (srst_in)
        strobe |=> st_r.base == $past(addr_in[ADDR_W-1:SBS_BURST_W]) && burst.low == $past(addr_in[SBS_BURST_W-1:0]);
    endproperty
    a_addr_load: assert property (p_addr_load) else $error("burst address not loaded at strobe");

    property p_start_beat;
        @(posedge core_clk_in) disable iff (srst_in)
        strobe |=> burst.cnt == SBS_BURST_ZERO;
    endproperty
    a_start_beat: assert property (p_start_beat) else $error("burst does not start at beat zero");

    property p_hold_no_adv;
        @(posedge core_clk_in) disable iff (srst_in)
        (!strobe && burst_advance_n_in) |=> $stable(burst.cnt);
    endproperty
    a_hold_no_adv: assert property (p_hold_no_adv) else $error("burst moved without advance");

    property p_no_strobe_hold;
        @(posedge core_clk_in) disable iff (srst_in)
        !strobe |=> $stable(st_r.base);
    endproperty
    a_no_strobe_hold: assert property (p_no_strobe_hold) else $error("address reloaded without strobe");

    property p_deselect;
        @(posedge core_clk_in) disable iff (srst_in)
        (strobe && !selected) |=> !st_r.active ##1 !dq_oe_out;
    endproperty
    a_deselect: assert property (p_deselect) else $error("deselected part drives the bus");

    // First beat stands on the bus two edges after a selected strobe
    property p_beat_timing;
        @(posedge core_clk_in) disable iff (srst_in)
        (strobe && selected) ##1 (!wr_any && !st_r.oe_n_sync && !st_r.sleep_sync) |=>
            dq_oe_out && dq_out == $past(mem_r[cur_addr]);
    endproperty
    a_beat_timing: assert property (p_beat_timing) else $error("read beat late or wrong");

    property p_oe_off;
        @(posedge core_clk_in) disable iff (srst_in)
        out_enable_n_in [*4] |-> !dq_oe_out;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("bus driven with output enable off");

    property p_sleep;
        @(posedge core_clk_in) disable iff (srst_in)
        sleep_request_in [*4] |-> sleep_active_out && !dq_oe_out ##1 !st_r.active;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep not entered");
endmodule : sbs_port

// >>> sbs_port_tb.sv
// Self-checking bench for the synchronous burst memory port
`timescale 1ns/100ps
module sbs_port_tb import sbs_pkg::*; ;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic [18:0] addr = '0;
    logic ps_n = 1'b1, cs_n = 1'b1, step_n = 1'b1, mode = 1'b0;
    logic pcs_n = 1'b0, dsh = 1'b1, dsl_n = 1'b0;
    logic [3:0] bw_n = 4'hF;
    logic qual_n = 1'b1, all_wr_n = 1'b1, oe_n = 1'b0, slp = 1'b0, drv = 1'b0;
    logic [35:0] wd = '0;
    logic [35:0] dq_in, dq_out;
    logic dq_oe, slp_act, red_oe;
    // Expected contents; the scenarios only touch word addresses below 0x400
    logic [35:0] mem [1024];
    int mismatches = 0;
    int n_compared = 0;
    int cyc = 0;

    sbs_port dut (.core_clk_in(core_clk), .srst_in(srst), .addr_in(addr),
        .processor_addr_strobe_n_in(ps_n), .controller_addr_strobe_n_in(cs_n), .burst_advance_n_in(step_n),
        .burst_mode_in(mode), .primary_chip_select_n_in(pcs_n), .depth_select_high_in(dsh),
        .depth_select_low_n_in(dsl_n), .byte_write_lane_n_in(bw_n), .byte_write_qualifier_n_in(qual_n),
        .global_write_n_in(all_wr_n), .out_enable_n_in(oe_n), .sleep_request_in(slp), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe_out(dq_oe), .sleep_active_out(slp_act));
    // Reduced variant on the same wires: only the primary select counts, and it never drives the bus
    sbs_port #(.DEPTH_SEL_EN(1'b0)) dut_red (.core_clk_in(core_clk), .srst_in(srst), .addr_in(addr),
        .processor_addr_strobe_n_in(ps_n), .controller_addr_strobe_n_in(cs_n), .burst_advance_n_in(step_n),
        .burst_mode_in(mode), .primary_chip_select_n_in(pcs_n), .depth_select_high_in(dsh),
        .depth_select_low_n_in(dsl_n), .byte_write_lane_n_in(bw_n), .byte_write_qualifier_n_in(qual_n),
        .global_write_n_in(all_wr_n), .out_enable_n_in(oe_n), .sleep_request_in(slp), .dq_in(dq_in),
        .dq_out(), .dq_oe_out(red_oe), .sleep_active_out());
    sbs_bus_model model (.core_clk_in(core_clk), .drive_in(drv), .wdata_in(wd), .dq_out_in(dq_out),
        .dq_oe_in(dq_oe), .bus_out(dq_in));

    // ------------------------------------------------------------------
    // Clock, timeout and shared tasks
    // ------------------------------------------------------------------
    initial begin
        forever #10 core_clk = ~core_clk;
    end

    // A hang is cut short well past the expected run of about a hundred cycles
    always @(posedge core_clk) begin
        cyc++;
        if (cyc >= 2000) begin
            mismatches++;
            test_done();
        end
    end

    task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One strobe, then four beats; reads are checked on the wire one cycle after each beat is launched
    task automatic burst(input logic [18:0] a, input logic md, input logic proc, input logic wr,
        input logic glob, input logic [3:0] lmask, input logic step);
        logic [18:0] ba;
        logic [1:0] lo;
        int j;
        @(negedge core_clk);
        addr = a;
        mode = md;
        ps_n = !proc;
        cs_n = proc;
        for (int k = 0; k <= 4; k++) begin
            @(negedge core_clk);
            ps_n = 1'b1;
            cs_n = 1'b1;
            step_n = !(step && k < 4);
            j = wr ? k : k - 1;
            lo = !step ? a[1:0] : (md ? (a[1:0] ^ 2'(j)) : (a[1:0] + 2'(j)));
            ba = {a[18:2], lo};
            drv = wr && k < 4;
            all_wr_n = !(drv && glob);
            qual_n = !(drv && !glob);
            bw_n = drv ? ~lmask : 4'hF;
            if (drv) begin
                wd = {17'h1A5C3, ba} ^ {4{9'(k)}};
                for (int l = 0; l < 4; l++) if (lmask[l]) mem[ba[9:0]][9*l +: 9] = wd[9*l +: 9];
            end
            if (wr && k > 0) check("oe while writing", dq_oe, 36'h0);
            if (!wr && k > 0) check("read beat", dq_in, mem[ba[9:0]]);
            if (!wr && k > 0) check("oe on read", dq_oe, 36'h1);
        end
    endtask : burst

    // A strobe that must not start an access on the full part; eo and ero are the
    // bus enables expected afterwards from the full and from the reduced part
    task automatic refused(input logic p, input logic pc_n, input logic dh, input logic dl_n, input logic eo,
        input logic ero);
        @(negedge core_clk);
        pcs_n = pc_n;
        dsh = dh;
        dsl_n = dl_n;
        ps_n = !p;
        cs_n = p;
        for (int i = 1; i <= 3; i++) begin
            @(negedge core_clk);
            ps_n = 1'b1;
            cs_n = 1'b1;
            pcs_n = 1'b0;
            dsh = 1'b1;
            dsl_n = 1'b0;
            if (i >= 2) check("oe after refused strobe", dq_oe, eo);
            if (i >= 2) check("reduced part oe", red_oe, ero);
        end
    endtask : refused

    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : test_done

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (10) @(negedge core_clk);
        srst = 1'b0;
        check("oe after reset", dq_oe, 36'h0);
        check("sleep after reset", slp_act, 36'h0);
        burst(19'h00101, 1'b0, 1'b0, 1'b1, 1'b1, 4'hF, 1'b1);
        burst(19'h00101, 1'b0, 1'b0, 1'b0, 1'b0, 4'hF, 1'b1);
        burst(19'h00102, 1'b1, 1'b1, 1'b0, 1'b0, 4'hF, 1'b1);
        burst(19'h00203, 1'b1, 1'b1, 1'b1, 1'b1, 4'hF, 1'b1);
        burst(19'h00200, 1'b0, 1'b0, 1'b0, 1'b0, 4'hF, 1'b1);
        burst(19'h00101, 1'b0, 1'b0, 1'b1, 1'b0, 4'h5, 1'b1);
        burst(19'h00101, 1'b0, 1'b1, 1'b0, 1'b0, 4'hF, 1'b1);
        burst(19'h00203, 1'b0, 1'b0, 1'b0, 1'b0, 4'hF, 1'b0);
        // Output enable is synchronised, so allow its three-edge delay each way
        oe_n = 1'b1;
        repeat (4) @(negedge core_clk);
        check("oe released", dq_oe, 36'h0);
        oe_n = 1'b0;
        repeat (4) @(negedge core_clk);
        check("oe restored", dq_oe, 36'h1);
        // An ignored processor strobe must leave the running burst on the bus
        refused(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
        refused(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
        refused(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1);
        slp = 1'b1;
        repeat (5) @(negedge core_clk);
        check("sleep entered", slp_act, 36'h1);
        refused(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
        slp = 1'b0;
        repeat (5) @(negedge core_clk);
        check("sleep left", slp_act, 36'h0);
        burst(19'h00200, 1'b1, 1'b0, 1'b0, 1'b0, 4'hF, 1'b1);
        test_done();
    end
endmodule : sbs_port_tb
